//--- shared/fsg_pkg.sv
package fsg_pkg;

    // ----------------------------------------------------------------
    // clocking
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ  = 125_000_000;
    localparam int unsigned REF_HZ  = 25_000_000;
    localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;

    // ----------------------------------------------------------------
    // register indices (byte address = 4 * index)
    // ----------------------------------------------------------------
    localparam int          IDX_W      = 6;
    localparam logic [5:0]  IDX_CTRL   = 6'h18;
    localparam logic [5:0]  IDX_HI_UP  = 6'h19;
    localparam logic [5:0]  IDX_HI_LO  = 6'h1a;
    localparam logic [5:0]  IDX_LO_UP  = 6'h1b;
    localparam logic [5:0]  IDX_LO_LO  = 6'h1c;
    localparam logic [5:0]  IDX_STATUS = 6'h3f;

    // ----------------------------------------------------------------
    // control fields and reset values
    // ----------------------------------------------------------------
    localparam int          CTL_EN       = 0;
    localparam int          CTL_STYLE    = 1;
    localparam int          CTL_INIT     = 2;
    localparam int          CTL_SINGLE   = 3;
    localparam int          MODE_LSB     = 4;
    localparam int          MODE_MSB     = 7;
    localparam int          MODE_EXT_BIT = 3;
    localparam int          MODE_REF_BIT = 2;
    localparam logic [7:0]  CTRL_RST     = 8'h00;
    localparam logic [7:0]  CTRL_WMASK   = 8'hf7;
    localparam logic [7:0]  TIME_RST     = 8'h00;
    localparam int          STA_LEVEL    = 0;
    localparam int          STA_SHOT     = 1;
    localparam int          STA_RUN      = 2;

    localparam int          PHASE_W = 24;

    typedef enum logic [1:0] {
        FSG_IDLE,
        FSG_HIGH,
        FSG_LOW,
        FSG_SHOT
    } fsg_state_e;

endpackage : fsg_pkg

//--- src/fsg_sync2.sv
`timescale 1ns/100ps
module fsg_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk_in,
    input  wire logic         resetn_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta_r;

    // first stage is read by the second stage only
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule : fsg_sync2

//--- src/fsg_tick.sv
`timescale 1ns/100ps
module fsg_tick #(
    parameter int DIV = 5
) (
    input  wire logic clk_in,
    input  wire logic resetn_in,
    output logic      tick_out
);
    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic          tick_nxt;

    always_comb begin
        tick_nxt = (cnt_r == LAST);
        cnt_nxt  = tick_nxt ? '0 : cnt_r + CW'(1);
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_r    <= '0;
            tick_out <= 1'b0;
        end else begin
            cnt_r    <= cnt_nxt;
            tick_out <= tick_nxt;
        end
    end
endmodule : fsg_tick

//--- src/fsg_top.sv
// How it works
// RULE1: codes 0000-0011 time from port frame clock
// RULE2: codes 01xx time from 25 MHz clock
// RULE3: codes 1xxx pass general pin 0-7 through
// RULE4: writing single-pulse bit emits one pulse
// RULE5: single-pulse bit self-clears, reads zero
// RULE6: host waits out a pulse before another
// RULE7: host keeps enable low for single pulses
// RULE8: initial-state bit sets starting output level
// RULE9: Hi/Lo mode times phases from separate values
// RULE10: 50/50 mode uses one 24-bit value
// RULE11: enable bit starts/stops generation, resets zero
// RULE12: high phase lasts programmed value plus one
// RULE13: high value zero gives one-cycle pulse
// RULE14: high bits 15:8 at 0x19, reset zero
// RULE15: high bits 7:0 at 0x1A, reset zero
// RULE16: low value at 0x1B/0x1C, minus-one coded
// RULE17: enabled alternates from initial level, else holds
`timescale 1ns/100ps
module fsg_top (
    input  wire logic        clk_in,
    input  wire logic        resetn_in,
    input  wire logic [7:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    input  wire logic [3:0]  avs_byteenable_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    input  wire logic [3:0]  bc_frame_clk_in,
    input  wire logic [7:0]  general_pin_in,
    output logic             frame_sync_signal_out
);
    localparam int PW = fsg_pkg::PHASE_W;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]   ctrl_r;
    logic [7:0]   ctrl_nxt;
    logic [7:0]   hi_up_r;
    logic [7:0]   hi_up_nxt;
    logic [7:0]   hi_lo_r;
    logic [7:0]   hi_lo_nxt;
    logic [7:0]   lo_up_r;
    logic [7:0]   lo_up_nxt;
    logic [7:0]   lo_lo_r;
    logic [7:0]   lo_lo_nxt;
    logic         shot_r;
    logic         shot_nxt;
    logic         wait_r;
    logic         wait_nxt;
    logic [31:0]  rdata_r;
    logic [31:0]  rdata_nxt;
    logic [PW-1:0] cnt_r;
    logic [PW-1:0] cnt_nxt;
    logic         out_r;
    logic         out_nxt;
    logic [3:0]   bc_d_r;
    fsg_pkg::fsg_state_e st_r;
    fsg_pkg::fsg_state_e st_nxt;

    logic [3:0]   bc_s;
    logic [7:0]   pin_s;
    logic         ref_tick;
    logic [3:0]   bc_rise;
    logic         tick;
    logic [PW-1:0] hi_len;
    logic [PW-1:0] lo_len;
    logic [3:0]   mode;
    logic         en;
    logic         init_lvl;
    logic         style;
    logic         ext;
    logic         req;
    logic         go;
    logic         acc_wr;
    logic         wr_ok;
    logic [fsg_pkg::IDX_W-1:0] idx;
    logic [7:0]   wbyte;
    logic [7:0]   rbyte;
    logic [7:0]   status;

    // ----------------------------------------------------------------
    // pin synchronisers and timing base
    // ----------------------------------------------------------------
    fsg_sync2 #(
        .W (12)
    ) u_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .d_in      ({general_pin_in, bc_frame_clk_in}),
        .q_out     ({pin_s, bc_s})
    );

    fsg_tick #(
        .DIV (fsg_pkg::REF_DIV)
    ) u_ref (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .tick_out  (ref_tick)
    );

    always_comb begin
        mode     = ctrl_r[fsg_pkg::MODE_MSB:fsg_pkg::MODE_LSB];
        en       = ctrl_r[fsg_pkg::CTL_EN];
        init_lvl = ctrl_r[fsg_pkg::CTL_INIT];
        style    = ctrl_r[fsg_pkg::CTL_STYLE];
        ext      = mode[fsg_pkg::MODE_EXT_BIT];
        bc_rise  = bc_s & ~bc_d_r;
        // one generator step per rising frame-clock edge or 25 MHz tick
        if (mode[fsg_pkg::MODE_REF_BIT]) begin
            tick = ref_tick;                                   // [RULE2]
        end else begin
            tick = bc_rise[mode[fsg_pkg::MODE_REF_BIT-1:0]];   // [RULE1]
        end
        // 50/50 drops the high upper byte and shares one length
        if (style) begin
            hi_len = {hi_lo_r, lo_up_r, lo_lo_r};              // [RULE10]
            lo_len = hi_len;
        end else begin
            hi_len = {8'h00, hi_up_r, hi_lo_r};                // [RULE9]
            lo_len = {8'h00, lo_up_r, lo_lo_r};                // [RULE16]
        end
    end

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle, then a one-cycle answer
    // ----------------------------------------------------------------
    always_comb begin
        req    = avs_read_in | avs_write_in;
        go     = req & wait_r;
        acc_wr = avs_write_in & ~wait_r;
        wr_ok  = acc_wr & avs_byteenable_in[0];
        idx    = avs_address_in[7:2];
        wbyte  = avs_writedata_in[7:0];
        wait_nxt = ~go;

        status = 8'h00;
        status[fsg_pkg::STA_LEVEL] = out_r;
        status[fsg_pkg::STA_SHOT]  = shot_r | (st_r == fsg_pkg::FSG_SHOT);
        status[fsg_pkg::STA_RUN]   = (st_r == fsg_pkg::FSG_HIGH)
                                   | (st_r == fsg_pkg::FSG_LOW);

        case (idx)
            fsg_pkg::IDX_CTRL:   rbyte = ctrl_r;   // single bit stored as 0 [RULE5]
            fsg_pkg::IDX_HI_UP:  rbyte = hi_up_r;
            fsg_pkg::IDX_HI_LO:  rbyte = hi_lo_r;
            fsg_pkg::IDX_LO_UP:  rbyte = lo_up_r;
            fsg_pkg::IDX_LO_LO:  rbyte = lo_lo_r;
            fsg_pkg::IDX_STATUS: rbyte = status;
            default:             rbyte = 8'h00;
        endcase
        rdata_nxt = (go & avs_read_in) ? {24'h00_0000, rbyte} : rdata_r;

        ctrl_nxt  = ctrl_r;
        hi_up_nxt = hi_up_r;
        hi_lo_nxt = hi_lo_r;
        lo_up_nxt = lo_up_r;
        lo_lo_nxt = lo_lo_r;
        if (wr_ok) begin
            case (idx)
                fsg_pkg::IDX_CTRL:  ctrl_nxt  = wbyte & fsg_pkg::CTRL_WMASK;
                fsg_pkg::IDX_HI_UP: hi_up_nxt = wbyte;                 // [RULE14]
                fsg_pkg::IDX_HI_LO: hi_lo_nxt = wbyte;                 // [RULE15]
                fsg_pkg::IDX_LO_UP: lo_up_nxt = wbyte;                 // [RULE16]
                fsg_pkg::IDX_LO_LO: lo_lo_nxt = wbyte;                 // [RULE16]
                default:            ctrl_nxt  = ctrl_r;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // generator
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r;
        // a request arriving while one is taken is kept: set wins
        shot_nxt = shot_r & (st_r != fsg_pkg::FSG_IDLE);
        if (wr_ok && idx == fsg_pkg::IDX_CTRL && wbyte[fsg_pkg::CTL_SINGLE]) begin
            shot_nxt = 1'b1;                                          // [RULE4]
        end
        case (st_r)
            fsg_pkg::FSG_IDLE: begin
                cnt_nxt = '0;
                if (en) begin
                    st_nxt = init_lvl ? fsg_pkg::FSG_HIGH
                                      : fsg_pkg::FSG_LOW;              // [RULE17]
                end else if (shot_r) begin
                    st_nxt = fsg_pkg::FSG_SHOT;                        // [RULE4]
                end
            end
            fsg_pkg::FSG_HIGH: begin
                if (!en) begin
                    st_nxt = fsg_pkg::FSG_IDLE;                        // [RULE11]
                end else if (tick) begin
                    if (cnt_r == hi_len) begin
                        cnt_nxt = '0;
                        st_nxt  = fsg_pkg::FSG_LOW;                    // [RULE12]
                    end else begin
                        cnt_nxt = cnt_r + PW'(1);
                    end
                end
            end
            fsg_pkg::FSG_LOW: begin
                if (!en) begin
                    st_nxt = fsg_pkg::FSG_IDLE;                        // [RULE11]
                end else if (tick) begin
                    if (cnt_r == lo_len) begin
                        cnt_nxt = '0;
                        st_nxt  = fsg_pkg::FSG_HIGH;                   // [RULE16]
                    end else begin
                        cnt_nxt = cnt_r + PW'(1);
                    end
                end
            end
            fsg_pkg::FSG_SHOT: begin
                // pulse of high-time length at the level opposite to idle
                if (tick) begin
                    if (cnt_r == hi_len) begin
                        cnt_nxt = '0;
                        st_nxt  = fsg_pkg::FSG_IDLE;                   // [RULE13]
                    end else begin
                        cnt_nxt = cnt_r + PW'(1);
                    end
                end
            end
            default: begin
                st_nxt  = fsg_pkg::FSG_IDLE;
                cnt_nxt = '0;
            end
        endcase
        if (ext) begin
            out_nxt = pin_s[mode[fsg_pkg::MODE_EXT_BIT-1:0]];          // [RULE3]
        end else begin
            case (st_nxt)
                fsg_pkg::FSG_HIGH: out_nxt = 1'b1;
                fsg_pkg::FSG_LOW:  out_nxt = 1'b0;
                fsg_pkg::FSG_SHOT: out_nxt = ~init_lvl;
                default:           out_nxt = init_lvl;                 // [RULE8]
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl_r  <= fsg_pkg::CTRL_RST;                              // [RULE11]
            hi_up_r <= fsg_pkg::TIME_RST;                              // [RULE14]
            hi_lo_r <= fsg_pkg::TIME_RST;                              // [RULE15]
            lo_up_r <= fsg_pkg::TIME_RST;
            lo_lo_r <= fsg_pkg::TIME_RST;
            shot_r  <= 1'b0;
            wait_r  <= 1'b1;
            rdata_r <= 32'h0000_0000;
            st_r    <= fsg_pkg::FSG_IDLE;
            cnt_r   <= '0;
            out_r   <= 1'b0;
            bc_d_r  <= 4'h0;
        end else begin
            ctrl_r  <= ctrl_nxt;
            hi_up_r <= hi_up_nxt;
            hi_lo_r <= hi_lo_nxt;
            lo_up_r <= lo_up_nxt;
            lo_lo_r <= lo_lo_nxt;
            shot_r  <= shot_nxt;
            wait_r  <= wait_nxt;
            rdata_r <= rdata_nxt;
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            out_r   <= out_nxt;
            bc_d_r  <= bc_s;
        end
    end

    assign avs_readdata_out      = rdata_r;
    assign avs_waitrequest_out   = wait_r;
    assign frame_sync_signal_out = out_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    logic rd_ctl_r;
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_ctl_r <= 1'b0;
        end else begin
            rd_ctl_r <= go & avs_read_in & (idx == fsg_pkg::IDX_CTRL);
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    a_port_tick: assert property (                                     // [RULE1]
        !ext && !mode[fsg_pkg::MODE_REF_BIT] && tick
        |-> bc_s[mode[fsg_pkg::MODE_REF_BIT-1:0]]
         && !bc_d_r[mode[fsg_pkg::MODE_REF_BIT-1:0]])
        else $error("tick without port frame clock edge");
    // a source switch to a port may land a frame-clock edge right after a tick
    a_ref_tick: assert property (                                      // [RULE2]
        mode[fsg_pkg::MODE_REF_BIT] && tick ##1 mode[fsg_pkg::MODE_REF_BIT] |-> !tick)
        else $error("reference tick longer than one cycle");
    a_ext_follow: assert property (                                    // [RULE3]
        ext && $stable(ctrl_r)
        |=> out_r == $past(pin_s[mode[fsg_pkg::MODE_EXT_BIT-1:0]]))
        else $error("external pin not passed through");
    a_shot_start: assert property (                                    // [RULE4]
        st_r == fsg_pkg::FSG_IDLE && shot_r && !en
        |=> st_r == fsg_pkg::FSG_SHOT ##0 !shot_r)
        else $error("single pulse request not taken");
    a_single_read0: assert property (                                  // [RULE5]
        rd_ctl_r |-> !avs_waitrequest_out
        && !avs_readdata_out[fsg_pkg::CTL_SINGLE])
        else $error("single pulse bit read as one");
    a_idle_level: assert property (                                    // [RULE8]
        st_r == fsg_pkg::FSG_IDLE && !en && !shot_r && !ext
        |=> out_r == $past(init_lvl))
        else $error("idle level differs from initial level");
    a_enable_start: assert property (                                  // [RULE17]
        st_r == fsg_pkg::FSG_IDLE && en
        |=> st_r == ($past(init_lvl) ? fsg_pkg::FSG_HIGH : fsg_pkg::FSG_LOW))
        else $error("generation did not start at initial level");
    a_high_hold: assert property (                                     // [RULE9]
        st_r == fsg_pkg::FSG_HIGH && en && tick && cnt_r != hi_len && !ext
        |=> st_r == fsg_pkg::FSG_HIGH && out_r && cnt_r == $past(cnt_r) + PW'(1))
        else $error("high phase ended early");
    a_high_end: assert property (                                      // [RULE12]
        st_r == fsg_pkg::FSG_HIGH && en && tick && cnt_r == hi_len && !ext
        |=> st_r == fsg_pkg::FSG_LOW && !out_r && cnt_r == '0)
        else $error("high phase not ended after value plus one");
    a_style_len: assert property (                                     // [RULE10]
        style |-> hi_len == lo_len && hi_len == {hi_lo_r, lo_up_r, lo_lo_r})
        else $error("50/50 length wrong");
    a_disable_idle: assert property (                                  // [RULE11]
        !en && (st_r == fsg_pkg::FSG_HIGH || st_r == fsg_pkg::FSG_LOW)
        |=> st_r == fsg_pkg::FSG_IDLE)
        else $error("generation not stopped by enable low");
    a_wait_answer: assert property (
        go |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("waitrequest answer not one cycle");

    c_shot_done: cover property (
        st_r == fsg_pkg::FSG_SHOT ##1 st_r == fsg_pkg::FSG_IDLE);
    c_run_cycle: cover property (
        st_r == fsg_pkg::FSG_LOW && style ##1 st_r == fsg_pkg::FSG_HIGH);
    c_ext_pass: cover property (ext && $rose(out_r));
endmodule : fsg_top

//--- tb/fsg_far_model.sv
`timescale 1ns/100ps
module fsg_far_model (
    input  wire logic        clk_in,
    input  wire logic        frame_sync_signal_in,
    output logic      [3:0]  bc_frame_clk_out,
    output logic      [31:0] hi_len_out,
    output logic      [31:0] lo_len_out,
    output logic      [31:0] rise_cnt_out
);
    // ----------------------------------------------------------------
    // back-channel frame clocks, port p has period 2*(p+2) clocks
    // ----------------------------------------------------------------
    logic [3:0]  cnt_r [4];
    logic [31:0] run_r;
    logic        last_r;

    initial begin
        bc_frame_clk_out = 4'h0;
        hi_len_out       = 32'h0000_0000;
        lo_len_out       = 32'h0000_0000;
        rise_cnt_out     = 32'h0000_0000;
        run_r            = 32'h0000_0000;
        last_r           = 1'b0;
        for (int p = 0; p < 4; p++) cnt_r[p] = 4'h0;
    end

    for (genvar p = 0; p < 4; p++) begin : g_port
        always @(posedge clk_in) begin
            if (cnt_r[p] == 4'(p + 1)) begin
                cnt_r[p]            <= 4'h0;
                bc_frame_clk_out[p] <= ~bc_frame_clk_out[p];
            end else begin
                cnt_r[p] <= cnt_r[p] + 4'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // sensor side: measures the length of each received level
    // ----------------------------------------------------------------
    always @(posedge clk_in) begin
        if (frame_sync_signal_in !== last_r) begin
            if (last_r === 1'b1) hi_len_out <= run_r;
            else lo_len_out <= run_r;
            if (frame_sync_signal_in === 1'b1) rise_cnt_out <= rise_cnt_out + 32'h0000_0001;
            run_r <= 32'h0000_0001;
        end else begin
            run_r <= run_r + 32'h0000_0001;
        end
        last_r <= frame_sync_signal_in;
    end
endmodule : fsg_far_model

//--- tb/frame_sync_generator_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module frame_sync_generator_tb_top;
    logic        clk_in            = 1'b0;
    logic        resetn_in         = 1'b0;
    logic [7:0]  avs_address_in    = 8'h00;
    logic        avs_read_in       = 1'b0;
    logic        avs_write_in      = 1'b0;
    logic [31:0] avs_writedata_in  = 32'h0000_0000;
    logic [3:0]  avs_byteenable_in = 4'h0;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic [3:0]  bc_frame_clk;
    logic [7:0]  general_pin_in    = 8'h00;
    logic        frame_sync_signal_out;
    logic [31:0] hi_len;
    logic [31:0] lo_len;
    logic [31:0] rise_cnt;
    logic [31:0] r0;
    int          bad_count = 0;
    int          tests_run = 0;

    always #4 clk_in = ~clk_in;

    fsg_top u_dut (
        .clk_in                (clk_in),
        .resetn_in             (resetn_in),
        .avs_address_in        (avs_address_in),
        .avs_read_in           (avs_read_in),
        .avs_write_in          (avs_write_in),
        .avs_writedata_in      (avs_writedata_in),
        .avs_byteenable_in     (avs_byteenable_in),
        .avs_readdata_out      (avs_readdata_out),
        .avs_waitrequest_out   (avs_waitrequest_out),
        .bc_frame_clk_in       (bc_frame_clk),
        .general_pin_in        (general_pin_in),
        .frame_sync_signal_out (frame_sync_signal_out)
    );

    fsg_far_model u_far (
        .clk_in               (clk_in),
        .frame_sync_signal_in (frame_sync_signal_out),
        .bc_frame_clk_out     (bc_frame_clk),
        .hi_len_out           (hi_len),
        .lo_len_out           (lo_len),
        .rise_cnt_out         (rise_cnt)
    );

    // ----------------------------------------------------------------
    // bus tasks
    // ----------------------------------------------------------------
    task automatic print_verdict;
        if (bad_count == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask : cyc

    task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [7:0] rd);
        int   n;
        logic ok;
        n = 0;
        @(posedge clk_in);
        avs_address_in    <= {idx, 2'b00};
        avs_write_in      <= wr;
        avs_read_in       <= ~wr;
        avs_writedata_in  <= {24'h00_0000, wd};
        avs_byteenable_in <= be;
        // request held until waitrequest is seen low at an edge
        do begin
            @(posedge clk_in);
            n++;
            ok = (avs_waitrequest_out === 1'b0);
        end while (!ok && n < 64);
        rd = avs_readdata_out[7:0];
        avs_write_in <= 1'b0;
        avs_read_in  <= 1'b0;
        if (!ok) begin
            bad_count++;
            print_verdict();
        end
    endtask : bus

    task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
        logic [7:0] d;
        bus(1'b1, idx, wd, 4'h1, d);
    endtask : wr

    task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        bus(1'b0, idx, 8'h00, 4'h1, d);
        `CHK(d, exp)
    endtask : rd_chk

    // restart from idle, run, then compare the last measured phases
    task automatic phase(input logic [7:0] ctl, input logic [31:0] eh, input logic [31:0] el);
        wr(fsg_pkg::IDX_CTRL, 8'h00);
        wr(fsg_pkg::IDX_CTRL, ctl);
        cyc(300);
        `CHK(hi_len, eh)
        `CHK(lo_len, el)
    endtask : phase

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        cyc(16);
        resetn_in <= 1'b1;
        cyc(2);
        `CHK(frame_sync_signal_out, 1'b0)
        rd_chk(fsg_pkg::IDX_CTRL, 8'h00);
        rd_chk(fsg_pkg::IDX_HI_UP, 8'h00);
        rd_chk(fsg_pkg::IDX_HI_LO, 8'h00);
        rd_chk(fsg_pkg::IDX_LO_UP, 8'h00);
        rd_chk(fsg_pkg::IDX_LO_LO, 8'h00);
        wr(fsg_pkg::IDX_HI_UP, 8'ha5);
        rd_chk(fsg_pkg::IDX_HI_UP, 8'ha5);
        bus(1'b1, fsg_pkg::IDX_HI_UP, 8'h5a, 4'h0, r0[7:0]);
        rd_chk(fsg_pkg::IDX_HI_UP, 8'ha5);
        wr(fsg_pkg::IDX_HI_LO, 8'h3c);
        rd_chk(fsg_pkg::IDX_HI_LO, 8'h3c);
        wr(fsg_pkg::IDX_LO_UP, 8'hc3);
        rd_chk(fsg_pkg::IDX_LO_UP, 8'hc3);
        rd_chk(6'h00, 8'h00);
        // 25 MHz base: one tick every 5 clocks
        wr(fsg_pkg::IDX_HI_UP, 8'h00);
        wr(fsg_pkg::IDX_HI_LO, 8'h02);
        wr(fsg_pkg::IDX_LO_UP, 8'h00);
        wr(fsg_pkg::IDX_LO_LO, 8'h04);
        phase(8'h41, 32'd15, 32'd25);
        phase(8'h71, 32'd15, 32'd25);
        wr(fsg_pkg::IDX_HI_LO, 8'h00);
        phase(8'h41, 32'd5, 32'd25);
        // upper high byte would dominate if 50/50 ignored the mode bit
        wr(fsg_pkg::IDX_HI_UP, 8'hff);
        wr(fsg_pkg::IDX_LO_LO, 8'h03);
        phase(8'h43, 32'd20, 32'd20);
        wr(fsg_pkg::IDX_HI_UP, 8'h00);
        wr(fsg_pkg::IDX_HI_LO, 8'h01);
        wr(fsg_pkg::IDX_LO_LO, 8'h02);
        for (int p = 0; p < 4; p++) begin
            phase(8'((p << 4) | 1), 32'(4 * (p + 2)), 32'(6 * (p + 2)));
        end
        // initial level, run and stop
        wr(fsg_pkg::IDX_LO_LO, 8'h03);
        wr(fsg_pkg::IDX_CTRL, 8'h44);
        cyc(3);
        `CHK(frame_sync_signal_out, 1'b1)
        rd_chk(fsg_pkg::IDX_STATUS, 8'h01);
        wr(fsg_pkg::IDX_HI_LO, 8'h10);
        r0 = rise_cnt;
        wr(fsg_pkg::IDX_CTRL, 8'h45);
        cyc(3);
        `CHK(frame_sync_signal_out, 1'b1)
        rd_chk(fsg_pkg::IDX_STATUS, 8'h05);
        cyc(300);
        `CHK((rise_cnt - r0) inside {[2:4]}, 1'b1)
        wr(fsg_pkg::IDX_CTRL, 8'h40);
        cyc(3);
        `CHK(frame_sync_signal_out, 1'b0)
        cyc(100);
        `CHK(frame_sync_signal_out, 1'b0)
        // single pulses, enable kept low and each pulse waited out
        wr(fsg_pkg::IDX_HI_LO, 8'h03);
        r0 = rise_cnt;
        wr(fsg_pkg::IDX_CTRL, 8'h48);
        rd_chk(fsg_pkg::IDX_CTRL, 8'h40);
        rd_chk(fsg_pkg::IDX_STATUS, 8'h03);
        cyc(200);
        `CHK(rise_cnt - r0, 32'h0000_0001)
        `CHK(hi_len inside {[16:20]}, 1'b1)
        wr(fsg_pkg::IDX_CTRL, 8'h48);
        cyc(200);
        `CHK(rise_cnt - r0, 32'h0000_0002)
        // external source: the other pins carry the opposite level
        for (int k = 0; k < 8; k++) begin
            wr(fsg_pkg::IDX_CTRL, 8'((8 + k) << 4));
            general_pin_in <= 8'h01 << k;
            cyc(6);
            `CHK(frame_sync_signal_out, 1'b1)
            general_pin_in <= ~(8'h01 << k);
            cyc(6);
            `CHK(frame_sync_signal_out, 1'b0)
        end
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk_in);
        bad_count++;
        print_verdict();
    end
endmodule : frame_sync_generator_tb_top
